// file: pfail_pkg.sv
/*
  Package for the power-fail and auto-restart block: timing constants,
  instruction code, start address table and sequence states.
  Assumes a single 100 MHz system clock.
*/
package pfail_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_NS = 250;
  localparam int STROBE_NS = 100;
  localparam int KEYSEL_NS = 100;
  localparam int RESTART_WAIT_MS = 1500;
  // line monitor delay: longer than one half-cycle of 50/60 Hz
  localparam int MONITOR_US = 12000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = STROBE_NS / CLK_PERIOD_NS;
  localparam int KEYSEL_CYC = (KEYSEL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESTART_CYC = RESTART_WAIT_MS * 100000;
  localparam int MONITOR_CYC = MONITOR_US * 100;

  // ----------------------------------------------------------------
  // instruction and addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] SKIP_OPCODE = 12'hC42;  // octal 6102
  localparam logic [2:0] SEL_ADDR_0000 = 3'h0;
  localparam logic [2:0] SEL_ADDR_0200 = 3'h1;
  localparam logic [2:0] SEL_ADDR_1000 = 3'h2;
  localparam logic [2:0] SEL_ADDR_2000 = 3'h3;
  localparam logic [2:0] SEL_ADDR_4000 = 3'h4;

  // ----------------------------------------------------------------
  // restart sequence states
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_WAIT   = 6'h02,
    ST_SETTLE = 6'h04,
    ST_STROBE = 6'h08,
    ST_START  = 6'h10,
    ST_FETCH  = 6'h20
  } seq_state_t;

endpackage

// file: delay_timer.sv
/*
  Retriggerable delay timer, the clocked stand-in for a one-shot.
  Assumes synchronous inputs on one clock.
*/
`timescale 1ns/100ps
`default_nettype none
module delay_timer #(
  parameter int COUNT = 4,
  parameter int W = 32
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // control
  input wire logic i_trig,
  // status
  output logic o_active,
  output logic o_expire
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic exp_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    exp_nxt = 1'b0;
    if (i_trig) begin
      cnt_nxt = W'(COUNT);
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - W'(1);
      exp_nxt = (cnt_r == W'(1));
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cnt_r <= '0;
      o_expire <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      o_expire <= exp_nxt;
    end
  end

  assign o_active = (cnt_r != '0);
endmodule
`default_nettype wire

// file: power_fail_auto_restart.sv
/*
  Power-fail detection and automatic restart sequencer.
  Assumes the line-monitor pulses and bus timing pulses are already
  synchronous to i_clk_sys; data bit outputs are open-drain, low active.
*/
`timescale 1ns/100ps
`default_nettype none
module power_fail_auto_restart #(
  parameter int RESTART_CYC = pfail_pkg::RESTART_CYC,
  parameter int MONITOR_CYC = pfail_pkg::MONITOR_CYC
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // line monitor
  input wire logic i_half_cycle,
  input wire logic i_above_restart,
  // configuration
  input wire logic i_restart_disable_switch,
  input wire logic [2:0] i_start_sel,
  // cpu bus
  input wire logic i_io_cycle,
  input wire logic [11:0] i_instr,
  input wire logic i_timing_pulse_one,
  // status and requests
  output logic o_line_good,
  output logic o_power_low_flag,
  output logic o_interrupt_request_line,
  output logic o_local_claim,
  output logic o_skip_request,
  // restart controls
  output logic o_load_addr_enable,
  output logic o_indicator_select_one,
  output logic o_state_decode_inhibit,
  output logic o_load_addr_strobe,
  output logic o_console_key_select,
  output logic o_mem_start,
  // data bits 0,1,2,4 as open-drain
  output logic [11:0] o_data,
  output logic [11:0] o_data_oe
);

  // ----------------------------------------------------------------
  // line monitor
  // ----------------------------------------------------------------
  logic mon_active;
  logic mon_expire;
  logic good_r;
  logic good_nxt;
  logic dir_r;
  logic dir_nxt;
  logic above_r;
  logic rise_ok;

  // the timer stays busy while half-cycles keep arriving
  delay_timer #(
    .COUNT(MONITOR_CYC),
    .W(32)
  ) u_monitor (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_trig(i_half_cycle),
    .o_active(mon_active),
    .o_expire(mon_expire)
  );

  // direction: armed out of reset, and again after seeing the line below threshold
  assign rise_ok = i_above_restart && !above_r && dir_r;

  always_comb begin
    good_nxt = good_r;
    dir_nxt = dir_r;
    if (!i_above_restart) begin
      dir_nxt = 1'b1;
    end else if (rise_ok) begin
      dir_nxt = 1'b0;
    end
    if (mon_expire) begin
      good_nxt = 1'b0;
    end else if (mon_active && i_above_restart && !good_r) begin
      good_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      good_r <= 1'b0;
      dir_r <= 1'b1;
      above_r <= 1'b0;
    end else begin
      good_r <= good_nxt;
      dir_r <= dir_nxt;
      above_r <= i_above_restart;
    end
  end

  // ----------------------------------------------------------------
  // restart sequencer
  // ----------------------------------------------------------------
  pfail_pkg::seq_state_t st_r;
  pfail_pkg::seq_state_t st_nxt;
  logic flag_r;
  logic flag_nxt;
  logic load_r;
  logic load_nxt;
  logic key_r;
  logic key_nxt;
  logic armed_r;
  logic armed_nxt;
  logic [1:0] nstrobe_r;
  logic [1:0] nstrobe_nxt;
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic [3:0] kcnt_r;
  logic [3:0] kcnt_nxt;
  logic good_rise;

  logic good_d_r;

  // restart triggers on the line-good edge, not on its level
  assign good_rise = good_r && !good_d_r;

  always_comb begin
    st_nxt = st_r;
    flag_nxt = flag_r;
    load_nxt = load_r;
    key_nxt = key_r;
    armed_nxt = armed_r;
    nstrobe_nxt = nstrobe_r;
    cnt_nxt = cnt_r;
    kcnt_nxt = kcnt_r;
    if (rise_ok) begin
      armed_nxt = 1'b1;
    end
    // key select asserts 100 ns after the first strobe rises, as that strobe ends
    if (kcnt_r != 4'h0) begin
      kcnt_nxt = kcnt_r - 4'h1;
      if (kcnt_r == 4'h1) begin
        key_nxt = 1'b0;
      end
    end
    case (st_r)
      pfail_pkg::ST_IDLE: begin
        if (good_rise && armed_r) begin
          armed_nxt = 1'b0;
          if (i_restart_disable_switch) begin
            flag_nxt = 1'b0;
          end else begin
            st_nxt = pfail_pkg::ST_WAIT;
            cnt_nxt = 32'(RESTART_CYC);
          end
        end
      end
      pfail_pkg::ST_WAIT: begin
        if (cnt_r <= 32'h1) begin
          st_nxt = pfail_pkg::ST_SETTLE;
          load_nxt = 1'b1;
          key_nxt = 1'b1;
          flag_nxt = 1'b0;
          nstrobe_nxt = 2'h0;
          cnt_nxt = 32'(pfail_pkg::SETTLE_CYC);
        end else begin
          cnt_nxt = cnt_r - 32'h1;
        end
      end
      pfail_pkg::ST_SETTLE: begin
        if (cnt_r <= 32'h1) begin
          if (load_r) begin
            st_nxt = pfail_pkg::ST_STROBE;
            cnt_nxt = 32'(pfail_pkg::STROBE_CYC);
            if (nstrobe_r == 2'h0) begin
              kcnt_nxt = 4'(pfail_pkg::KEYSEL_CYC);
            end
          end else begin
            st_nxt = pfail_pkg::ST_START;
            cnt_nxt = 32'(pfail_pkg::STROBE_CYC);
          end
        end else begin
          cnt_nxt = cnt_r - 32'h1;
        end
      end
      pfail_pkg::ST_STROBE: begin
        // settle time runs from the strobe's leading edge, so the
        // remaining settle after the strobe is the difference
        if (cnt_r <= 32'h1) begin
          nstrobe_nxt = nstrobe_r + 2'h1;
          if (nstrobe_r == 2'h1) begin
            load_nxt = 1'b0;
          end
          st_nxt = pfail_pkg::ST_SETTLE;
          cnt_nxt = 32'(pfail_pkg::SETTLE_CYC - pfail_pkg::STROBE_CYC);
        end else begin
          cnt_nxt = cnt_r - 32'h1;
        end
      end
      pfail_pkg::ST_START: begin
        if (cnt_r <= 32'h1) begin
          st_nxt = pfail_pkg::ST_FETCH;
        end else begin
          cnt_nxt = cnt_r - 32'h1;
        end
      end
      pfail_pkg::ST_FETCH: begin
        if (i_timing_pulse_one) begin
          key_nxt = 1'b1;
          st_nxt = pfail_pkg::ST_IDLE;
        end
      end
      default: begin
        st_nxt = pfail_pkg::ST_IDLE;
      end
    endcase
    // set wins over any clear in the same cycle
    if (mon_expire) begin
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_r <= pfail_pkg::ST_IDLE;
      flag_r <= 1'b0;
      load_r <= 1'b0;
      key_r <= 1'b1;
      armed_r <= 1'b0;
      nstrobe_r <= 2'h0;
      cnt_r <= 32'h0;
      kcnt_r <= 4'h0;
      good_d_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      flag_r <= flag_nxt;
      load_r <= load_nxt;
      key_r <= key_nxt;
      armed_r <= armed_nxt;
      nstrobe_r <= nstrobe_nxt;
      cnt_r <= cnt_nxt;
      kcnt_r <= kcnt_nxt;
      good_d_r <= good_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic skip_dec;
  logic strobe_on;
  logic [11:0] pull;

  assign skip_dec = i_io_cycle && (i_instr == pfail_pkg::SKIP_OPCODE);
  assign strobe_on = (st_r == pfail_pkg::ST_STROBE);

  // data bit 0 is the msb: 4000 pulls bit 0, 2000 bit 1, 1000 bit 2,
  // 0200 bit 4; location zero pulls none
  always_comb begin
    pull = 12'h000;
    case (i_start_sel)
      pfail_pkg::SEL_ADDR_0200: pull = 12'h080;
      pfail_pkg::SEL_ADDR_1000: pull = 12'h200;
      pfail_pkg::SEL_ADDR_2000: pull = 12'h400;
      pfail_pkg::SEL_ADDR_4000: pull = 12'h800;
      default: pull = 12'h000;
    endcase
  end

  assign o_line_good = good_r;
  assign o_power_low_flag = flag_r;
  assign o_interrupt_request_line = flag_r;
  assign o_local_claim = skip_dec;
  assign o_skip_request = skip_dec && flag_r;
  assign o_load_addr_enable = load_r;
  assign o_indicator_select_one = load_r;
  assign o_state_decode_inhibit = load_r;
  assign o_load_addr_strobe = strobe_on;
  assign o_console_key_select = !key_r;
  assign o_mem_start = (st_r == pfail_pkg::ST_START);
  assign o_data = 12'h000;
  assign o_data_oe = strobe_on ? pull : 12'h000;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb_sys @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  sequence s_strobe_end;
    $fell(o_load_addr_strobe);
  endsequence

  // strobe holds for exactly ten cycles, then drops
  sequence s_strobe_body;
    o_load_addr_strobe [*8] ##1 o_load_addr_strobe [*2]
    ##1 !o_load_addr_strobe;
  endsequence

  AST_EXPIRE_FLAG: assert property (mon_expire |=>
    o_power_low_flag && !o_line_good)
    else $error("expiry did not raise flag");
  AST_SKIP: assert property (o_skip_request |->
    o_local_claim && o_power_low_flag)
    else $error("skip without flag");
  AST_CLAIM: assert property (
    (i_io_cycle && i_instr == 12'hC42) |-> o_local_claim)
    else $error("skip instruction not claimed");
  AST_TOGETHER: assert property (
    o_load_addr_enable == o_state_decode_inhibit)
    else $error("enable and inhibit differ");
  AST_STROBE_LEN: assert property (
    $rose(o_load_addr_strobe) |-> s_strobe_body)
    else $error("strobe width wrong");
  AST_KEY_CLR: assert property (
    ($rose(o_load_addr_strobe) && !o_console_key_select) |->
    ##10 o_console_key_select)
    else $error("key select not asserted");
  AST_LOAD_END: assert property (
    (s_strobe_end ##0 (nstrobe_r == 2'h2)) |-> !o_load_addr_enable)
    else $error("load not cleared after second strobe");
  AST_MEMSTART: assert property (
    o_mem_start |-> !o_load_addr_strobe && !o_load_addr_enable)
    else $error("memory start with strobe");
  AST_DATA: assert property (
    (o_data_oe != 12'h000) |-> o_load_addr_strobe)
    else $error("data driven outside strobe");
  AST_FETCH_KEY: assert property (
    (st_r == pfail_pkg::ST_FETCH && i_timing_pulse_one) |=>
    !o_console_key_select)
    else $error("key select not released");
  AST_WAIT_END: assert property (
    (st_r == pfail_pkg::ST_WAIT && cnt_r <= 32'h1 && !mon_expire) |=>
    o_load_addr_enable && !o_console_key_select && !o_power_low_flag)
    else $error("wait end did not start loading");
  AST_DISABLE: assert property (
    (st_r == pfail_pkg::ST_IDLE && good_rise && armed_r &&
    i_restart_disable_switch && !mon_expire) |=>
    !o_power_low_flag && st_r == pfail_pkg::ST_IDLE)
    else $error("disabled restart still ran");
endmodule
`default_nettype wire

// file: cpu_model.sv
/*
  Behavioural host processor facing the restart sequencer: loads the
  address register on a plain strobe, the field registers on a keyed one,
  and gives a first timing pulse after the start pulse.
  Assumes all inputs are synchronous to i_clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none
module cpu_model (
  // clock and bench control
  input wire logic i_clk_sys,
  input wire logic i_clear,
  // from the sequencer
  input wire logic i_strobe,
  input wire logic i_key_sel,
  input wire logic [11:0] i_data_oe,
  input wire logic i_mem_start,
  // to the sequencer and bench
  output logic o_tp1,
  output logic [11:0] o_mem_addr_reg,
  output logic [3:0] o_field_loads,
  output logic [7:0] o_strobe_cyc
);
  logic prev_s;
  logic prev_m;
  logic [1:0] dly;

  initial begin
    o_tp1 = 1'b0;
    o_mem_addr_reg = 12'hFFF;
    o_field_loads = 4'h0;
    o_strobe_cyc = 8'h00;
    prev_s = 1'b0;
    prev_m = 1'b0;
    dly = 2'h0;
  end

  always @(posedge i_clk_sys) begin
    prev_s <= i_strobe;
    prev_m <= i_mem_start;
    o_tp1 <= (dly == 2'h1);
    if (i_clear) begin
      o_mem_addr_reg <= 12'hFFF;
      o_field_loads <= 4'h0;
      o_strobe_cyc <= 8'h00;
    end else begin
      if (i_strobe)
        o_strobe_cyc <= o_strobe_cyc + 8'h01;
      // pulled-low lines read as ones on the bus
      if (i_strobe && !prev_s && !i_key_sel)
        o_mem_addr_reg <= i_data_oe;
      if (i_strobe && !prev_s && i_key_sel)
        o_field_loads <= o_field_loads + 4'h1;
    end
    // timing runs once the start pulse ends; the sequencer only
    // listens for the first timing pulse after that
    if (!i_mem_start && prev_m)
      dly <= 2'h3;
    else if (dly != 2'h0)
      dly <= dly - 2'h1;
  end
endmodule
`default_nettype wire

// file: testbench.sv
/*
  Self-checking bench for the power-fail and auto-restart sequencer.
  Assumes short restart and monitor counts set by parameter.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic hc_en = 1'b0;
  logic i_half_cycle = 1'b0;
  logic i_above_restart = 1'b0;
  logic i_restart_disable_switch = 1'b0;
  logic [2:0] i_start_sel = 3'h0;
  logic i_io_cycle = 1'b0;
  logic [11:0] i_instr = 12'h000;
  logic tp1, line_good, flag, irq, claim, skip, la_en, ind, inh;
  logic strobe, key_sel, mem_start, clr, lg_ok;
  logic [11:0] data, data_oe, addr;
  logic [3:0] fld;
  logic [7:0] scyc;
  logic [7:0] hc_cnt = 8'h00;
  int fail_count = 0;
  int n_checks = 0;
  int i;
  typedef struct {logic io; logic [11:0] ins; logic cl;} row_t;
  row_t rows[4] = '{'{1'b1, 12'hC42, 1'b1}, '{1'b0, 12'hC42, 1'b0},
    '{1'b1, 12'hC41, 1'b0}, '{1'b1, 12'hC43, 1'b0}};
  logic [11:0] exp_addr[8] = '{12'h000, 12'h080, 12'h200, 12'h400,
    12'h800, 12'h000, 12'h000, 12'h000};

  always #5 i_clk_sys = ~i_clk_sys;

  // healthy line: a pulse every 40 cycles keeps the 50-cycle monitor
  // busy, while one missing pulse leaves an 80-cycle gap that expires it
  always @(posedge i_clk_sys) begin
    hc_cnt <= (hc_cnt == 8'h27) ? 8'h00 : hc_cnt + 8'h01;
    i_half_cycle <= #1 hc_en && (hc_cnt == 8'h00);
  end

  // the three restart controls must always move together
  always @(posedge i_clk_sys)
    if (!i_rst && !(la_en === ind && la_en === inh))
      lg_ok <= 1'b0;

  power_fail_auto_restart #(.RESTART_CYC(100), .MONITOR_CYC(50)) dut_u (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_half_cycle(i_half_cycle),
    .i_above_restart(i_above_restart),
    .i_restart_disable_switch(i_restart_disable_switch),
    .i_start_sel(i_start_sel), .i_io_cycle(i_io_cycle), .i_instr(i_instr),
    .i_timing_pulse_one(tp1), .o_line_good(line_good),
    .o_power_low_flag(flag), .o_interrupt_request_line(irq),
    .o_local_claim(claim), .o_skip_request(skip),
    .o_load_addr_enable(la_en), .o_indicator_select_one(ind),
    .o_state_decode_inhibit(inh), .o_load_addr_strobe(strobe),
    .o_console_key_select(key_sel), .o_mem_start(mem_start),
    .o_data(data), .o_data_oe(data_oe));

  cpu_model cpu_u (.i_clk_sys(i_clk_sys), .i_clear(clr), .i_strobe(strobe),
    .i_key_sel(key_sel), .i_data_oe(data_oe), .i_mem_start(mem_start),
    .o_tp1(tp1), .o_mem_addr_reg(addr), .o_field_loads(fld),
    .o_strobe_cyc(scyc));

  task automatic results();
    if (fail_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmp(string what, logic [11:0] exp, logic [11:0] got);
    n_checks++;
    if (exp !== got) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask

  task automatic wait_for(ref logic s, input int lim);
    for (int k = 0; k < lim && s !== 1'b1; k++)
      tick(1);
  endtask

  // ----------------------------------------------------------------
  // supply loss: brief dip, flag and request stay until restart or until the disable switch skips it
  // ----------------------------------------------------------------
  task automatic power_fail();
    hc_en = 1'b0;
    i_above_restart = 1'b0;
    // longer than one pulse spacing, so at least one half-cycle is lost
    tick(45);
    hc_en = 1'b1;
    i_above_restart = 1'b1;
    wait_for(flag, 60);
    cmp("flag", 12'h1, {11'h0, flag});
    cmp("irq", 12'h1, {11'h0, irq});
    i_io_cycle = 1'b1;
    i_instr = 12'hC42;
    tick(1);
    cmp("skip set", 12'h3, {10'h0, claim, skip});
    i_io_cycle = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // restart walk checked through the processor model
  // ----------------------------------------------------------------
  task automatic restart(logic [2:0] sel);
    i_start_sel = sel;
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    wait_for(mem_start, 400);
    cmp("mem start", 12'h1, {11'h0, mem_start});
    cmp("flag clear", 12'h0, {11'h0, flag});
    cmp("address", exp_addr[sel], addr);
    cmp("field loads", 12'h1, {8'h0, fld});
    cmp("strobe cycles", 12'h014, {4'h0, scyc});
    cmp("load off", 12'h0, {11'h0, la_en});
    cmp("key select on", 12'h1, {11'h0, key_sel});
    cmp("data level", 12'h000, data);
    wait_for(tp1, 20);
    tick(2);
    cmp("key select", 12'h0, {11'h0, key_sel});
  endtask

  initial begin
    clr = 1'b0;
    lg_ok = 1'b1;
    tick(3);
    i_rst = 1'b0;
    cmp("reset", 12'h0, {9'h0, line_good, flag, mem_start});
    for (i = 0; i < 4; i++) begin
      i_io_cycle = rows[i].io;
      i_instr = rows[i].ins;
      tick(1);
      cmp("claim", {11'h0, rows[i].cl}, {11'h0, claim});
      cmp("skip clear", 12'h0, {11'h0, skip});
    end
    i_io_cycle = 1'b0;
    hc_en = 1'b1;
    i_above_restart = 1'b1;
    wait_for(line_good, 100);
    cmp("line good", 12'h1, {11'h0, line_good});
    restart(3'h0);
    for (i = 0; i < 8; i++) begin
      power_fail();
      cmp("line low", 12'h0, {11'h0, line_good});
      restart(i[2:0]);
    end
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    i_restart_disable_switch = 1'b1;
    power_fail();
    tick(300);
    cmp("disabled flag", 12'h0, {11'h0, flag});
    cmp("no strobe", 12'h0, {4'h0, scyc});
    cmp("tied controls", 12'h1, {11'h0, lg_ok});
    results();
  end

  initial begin
    #400000;
    fail_count++;
    results();
  end
endmodule
`default_nettype wire
